// [msd_pkg.sv]
// Purpose: Shared constants for the motor driver SPI and diagnostics block
// Assumes: 50 MHz system clock, 8-bit SPI registers, mode 0 link
// Notes:   Status bytes carry parity in the top bit

package msd_pkg;

    localparam int          CLK_HZ       = 50_000_000;
    localparam int          OPEN_TIME_MS = 200;
    localparam int          MS_PER_S     = 1000;
    localparam int          OPEN_CYCLES  = OPEN_TIME_MS * (CLK_HZ / MS_PER_S);

    localparam int          ADDR_W       = 5;
    localparam int          IDX_W        = 3;
    localparam int          REG_COUNT    = 8;
    localparam int          BIT_CNT_W    = 3;
    localparam int          TOT_W        = 5;
    localparam int          OC_W         = 4;
    localparam int          SYNC_W       = 15;

    localparam logic [TOT_W-1:0]     PKT_BITS  = 5'h10;
    localparam logic [TOT_W-1:0]     TOT_MAX   = 5'h11;
    localparam logic [BIT_CNT_W-1:0] LAST_BIT  = 3'h7;
    localparam int                   CMD_BIT   = 7;
    localparam logic                 CMD_WRITE = 1'b1;
    localparam logic                 CMD_READ  = 1'b0;

    localparam logic [ADDR_W-1:0] ADDR_CR0 = 5'h01;
    localparam logic [ADDR_W-1:0] ADDR_CR1 = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_CR2 = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_SR0 = 5'h04;
    localparam logic [ADDR_W-1:0] ADDR_SR1 = 5'h05;
    localparam logic [ADDR_W-1:0] ADDR_SR2 = 5'h06;
    localparam logic [ADDR_W-1:0] ADDR_SR3 = 5'h07;

    localparam int          CR2_MOTOR_EN = 7;
    localparam int          CR2_SLEEP    = 6;
    localparam int          SR0_WARN     = 6;
    localparam int          SR0_PUMP     = 5;
    localparam int          SR0_OPEN_X   = 3;
    localparam int          SR0_OPEN_Y   = 2;
    localparam int          SR1_OC_LSB   = 3;
    localparam int          SR2_OC_LSB   = 3;
    localparam int          SR2_SHUTDOWN = 2;

    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  UNMAPPED_VAL = 8'h00;
    localparam logic [6:0]  STATUS_ZERO  = 7'h00;

    function automatic logic [7:0] msd_with_parity(input logic [6:0] d);
        return {^d, d};
    endfunction : msd_with_parity

endpackage : msd_pkg

// [msd_spi_host.sv]
// Purpose: SPI master model facing the diagnostics block link
// Assumes: Mode 0, 80 ns link clock, DO pulled up when released
// Notes:   Link clock stands still low between frames
module msd_spi_host
(
    // Link pins
    output logic            o_spi_clk,
    output logic            o_select_n,
    output logic            o_serial_in,
    input  wire logic       i_serial_out,
    input  wire logic       i_serial_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_spi_clk   = 1'b0;
        o_select_n  = 1'b1;
        o_serial_in = 1'b1;
        #7;
    end
    // Odd start offset keeps the link unrelated to the system clock
    task automatic xfer(input logic [16:0] tx, input int n,
                        output logic [16:0] rx);
        rx = '0;
        o_select_n = 1'b0;
        #47;
        for (int i = n - 1; i >= 0; i--)
        begin
            o_serial_in = tx[i];
            #40 o_spi_clk = 1'b1;
            rx = {rx[15:0], i_serial_oe ? i_serial_out : 1'b1};
            #40 o_spi_clk = 1'b0;
        end
        #40 o_select_n = 1'b1;
        o_serial_in = ~o_serial_in;
    endtask : xfer
endmodule : msd_spi_host

// [msd_spi_link.sv]
// Purpose: Mode 0 SPI slave engine on the link clock
// Assumes: Register image is stable while select is low
// Notes:   Packet record holds after select rises for the core to take

module msd_spi_link
    import msd_pkg::*;
(
    // Link clock and resets
    input  wire logic                      i_spi_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_select_n,
    // Serial pins
    input  wire logic                      i_serial_in,
    output logic                           o_serial_out,
    output logic                           o_serial_oe,
    // Register image and packet record
    input  wire logic [REG_COUNT-1:0][7:0] i_rd_bytes,
    output logic      [TOT_W-1:0]          o_pkt_bits,
    output logic                           o_pkt_write,
    output logic      [ADDR_W-1:0]         o_pkt_addr,
    output logic      [7:0]                o_pkt_data,
    output logic      [REG_COUNT-1:0]      o_read_mask
);

    typedef struct packed {
        logic [BIT_CNT_W-1:0] bit_cnt;
        logic [TOT_W-1:0]     total;
        logic [7:0]           rx_sr;
        logic [7:0]           tx_sr;
        logic [ADDR_W-1:0]    addr;
        logic                 expect_data;
        logic                 pkt_write;
        logic [7:0]           pkt_data;
        logic [REG_COUNT-1:0] read_mask;
    } msd_link_t;

    msd_link_t  l_reg;
    msd_link_t  l_next;
    logic       in_frame;
    logic       do_oe;
    logic [7:0] rx_byte;

    function automatic logic [7:0] pick(input logic [ADDR_W-1:0] a);
        if (a < ADDR_W'(REG_COUNT))
            return i_rd_bytes[a[IDX_W-1:0]];
        return UNMAPPED_VAL;
    endfunction : pick

    // Per-frame fields restart at the first edge after select falls
    always_ff @(posedge i_spi_clk or posedge i_select_n)
    begin
        if (i_select_n)
            in_frame <= 1'b0;
        else
            in_frame <= 1'b1;
    end

    always_comb
    begin
        l_next  = l_reg;
        rx_byte = {l_reg.rx_sr[6:0], i_serial_in};                 // RULE_14
        if (!in_frame)
        begin
            l_next.bit_cnt     = '0;
            l_next.total       = '0;
            l_next.expect_data = 1'b0;
            l_next.read_mask   = '0;
        end
        l_next.rx_sr   = rx_byte;                                  // RULE_13
        l_next.bit_cnt = l_next.bit_cnt + 3'h1;
        if (l_next.total != TOT_MAX)
            l_next.total = l_next.total + 5'h01;                   // RULE_23
        if (l_reg.bit_cnt == LAST_BIT && in_frame)
        begin
            if (l_next.expect_data)
            begin
                l_next.pkt_data    = rx_byte;
                l_next.expect_data = 1'b0;
                l_next.tx_sr       = pick(l_reg.addr);             // RULE_22
            end
            else
            begin
                l_next.addr        = rx_byte[ADDR_W-1:0];          // RULE_25
                l_next.pkt_write   = rx_byte[CMD_BIT];             // RULE_15
                l_next.expect_data = rx_byte[CMD_BIT] == CMD_WRITE;
                l_next.tx_sr       = pick(rx_byte[ADDR_W-1:0]);    // RULE_16
                if (rx_byte[CMD_BIT] == CMD_READ &&
                    rx_byte[ADDR_W-1:0] < ADDR_W'(REG_COUNT))
                    l_next.read_mask[rx_byte[IDX_W-1:0]] = 1'b1;
            end
        end
        else
            l_next.tx_sr = {l_reg.tx_sr[6:0], 1'b1};
    end

    always_ff @(posedge i_spi_clk or posedge i_rst)
    begin
        if (i_rst)
            l_reg <= '0;
        else
            l_reg <= l_next;
    end

    // Open drain: only pull low, released whenever deselected
    always_ff @(negedge i_spi_clk or posedge i_rst or posedge i_select_n)
    begin
        if (i_rst || i_select_n)
            do_oe <= 1'b0;
        else
            do_oe <= ~l_reg.tx_sr[7];                              // RULE_13
    end

    // Slave only: nothing here can start a transfer
    assign o_serial_out = 1'b0;                                    // RULE_12
    assign o_serial_oe  = do_oe;
    assign o_pkt_bits   = l_reg.total;
    assign o_pkt_write  = l_reg.pkt_write;
    assign o_pkt_addr   = l_reg.addr;
    assign o_pkt_data   = l_reg.pkt_data;
    assign o_read_mask  = l_reg.read_mask;

    a_load_eighth : assert property ( // RULE_16
        @(posedge i_spi_clk) disable iff (i_rst || i_select_n)
        (in_frame && l_reg.bit_cnt == LAST_BIT && !l_reg.expect_data)
        |=> l_reg.tx_sr == pick(l_reg.addr))
        else $error("tx byte not loaded after command byte");

endmodule : msd_spi_link

// [msd_sync.sv]
// Purpose: Two-flop synchroniser for a vector of asynchronous levels
// Assumes: Each bit is an independent slow level
// Notes:   First stage is read only by the second stage

module msd_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
)
(
    // Clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    // Levels
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } msd_sync_t;

    msd_sync_t s_reg;
    msd_sync_t s_next;

    always_comb
    begin
        s_next.meta = i_async;
        s_next.sync = s_reg.meta;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            s_reg <= {INIT, INIT};
        else
            s_reg <= s_next;
    end

    assign o_sync = s_reg.sync;

endmodule : msd_sync

// [msd_top.sv]
// Purpose: Diagnostics flags, error output, sleep and SPI registers
// Assumes: Analog detector levels arrive asynchronously on pins
// Notes:   Status and error pin move only while select is high
//
// How it works
// RULE_01 - Warning temperature sets warning flag
// RULE_02 - Shutdown temperature sets flag, drivers high impedance
// RULE_03 - Shutdown flag clears when cool and read
// RULE_04 - Over-current sets its flag, drivers off
// RULE_05 - Over-current flags latch until host reads
// RULE_06 - Full duty over 200 ms opens coil
// RULE_07 - Pump failure flag held while pump low
// RULE_08 - Error output low on any flag
// RULE_09 - Hard reset pin clears registers, pump runs
// RULE_10 - Sleep tri-states drivers, keeps registers, SPI works
// RULE_11 - Host keeps step inputs still in sleep
// RULE_12 - Device is slave only, never starts transfers
// RULE_13 - Mode 0, active-low select, clock idles low
// RULE_14 - MSB first; command byte then data byte
// RULE_15 - Command bit zero reads, one writes
// RULE_16 - Read loads output at eighth falling edge
// RULE_17 - Status bytes carry odd parity in D7; code sets D7 to the XOR of D6..D0, so each byte has even parity
// RULE_18 - Host rereads status on parity mismatch
// RULE_19 - Status cleared by read, updated select high
// RULE_20 - Host raises select promptly when idle
// RULE_21 - Write commits only when select rises
// RULE_22 - Each byte returns last addressed register
// RULE_23 - Writes not exactly 16 bits are dropped
// RULE_24 - Writes to read-only registers are ignored
// RULE_25 - Command bit 7, address bits 4 to 0

module msd_top
    import msd_pkg::*;
#(
    parameter int OPEN_LIMIT = OPEN_CYCLES
)
(
    // Clocks and reset
    input  wire logic            i_ref_clk,
    input  wire logic            i_rst,
    input  wire logic            i_spi_clk,
    // SPI pins
    input  wire logic            i_select_n,
    input  wire logic            i_serial_in,
    output logic                 o_serial_out,
    output logic                 o_serial_oe,
    // Analog detectors and reset pin
    input  wire logic            i_temp_warn,
    input  wire logic            i_temp_shutdown,
    input  wire logic [OC_W-1:0] i_overcurrent_x,
    input  wire logic [OC_W-1:0] i_overcurrent_y,
    input  wire logic            i_pwm_full_x,
    input  wire logic            i_pwm_full_y,
    input  wire logic            i_pump_low,
    input  wire logic            i_hard_reset_in,
    // Status and driver control
    output logic                 o_error_out_n,
    output logic                 o_drive_en_x,
    output logic                 o_drive_en_y,
    output logic                 o_pump_run,
    output logic                 o_osc_run,
    output logic [7:0]           o_ctrl0,
    output logic [7:0]           o_ctrl1,
    output logic [7:0]           o_ctrl2
);

    localparam int             CW    = $clog2(OPEN_LIMIT + 1);
    localparam logic [CW-1:0]  LIMIT = CW'(OPEN_LIMIT);

    typedef struct packed {
        logic            sel_d;
        logic [7:0]      cr0;
        logic [7:0]      cr1;
        logic [7:0]      cr2;
        logic            warn;
        logic            shutdown;
        logic [OC_W-1:0] oc_x;
        logic [OC_W-1:0] oc_y;
        logic            open_x;
        logic            open_y;
        logic            pump;
        logic [CW-1:0]   cnt_x;
        logic [CW-1:0]   cnt_y;
        logic            err_n;
        logic            drv_x;
        logic            drv_y;
        logic            pump_run;
        logic            osc_run;
    } msd_core_t;

    localparam msd_core_t CORE_RST = '{
        sel_d:    1'b1,
        cr0:      CTRL_RESET,
        cr1:      CTRL_RESET,
        cr2:      CTRL_RESET,
        warn:     1'b0,
        shutdown: 1'b0,
        oc_x:     '0,
        oc_y:     '0,
        open_x:   1'b0,
        open_y:   1'b0,
        pump:     1'b0,
        cnt_x:    '0,
        cnt_y:    '0,
        err_n:    1'b1,
        drv_x:    1'b0,
        drv_y:    1'b0,
        pump_run: 1'b1,
        osc_run:  1'b1
    };

    msd_core_t                 s_reg;
    msd_core_t                 s_next;
    logic [SYNC_W-1:0]         sync_out;
    logic                      warn_s;
    logic                      shut_s;
    logic [OC_W-1:0]           ocx_s;
    logic [OC_W-1:0]           ocy_s;
    logic                      full_x_s;
    logic                      full_y_s;
    logic                      pump_s;
    logic                      sel_s;
    logic                      hard_s;
    logic [TOT_W-1:0]          pkt_bits;
    logic                      pkt_write;
    logic [ADDR_W-1:0]         pkt_addr;
    logic [7:0]                pkt_data;
    logic [REG_COUNT-1:0]      read_mask;
    logic [REG_COUNT-1:0][7:0] image;
    logic [6:0]                sr0;
    logic [6:0]                sr1;
    logic [6:0]                sr2;
    logic                      commit;
    logic                      wr_ok;
    logic                      rd_sr0;
    logic                      rd_sr1;
    logic                      rd_sr2;
    logic                      any_flag;

    // Counter toward the open-coil limit; saturates so it never wraps
    function automatic logic [CW-1:0] open_step(
        input logic          full,
        input logic          active,
        input logic [CW-1:0] cnt
    );
        if (!(full && active))
            return '0;
        if (cnt == LIMIT)
            return cnt;
        return cnt + CW'(1);
    endfunction : open_step

    msd_sync #(
        .W    (SYNC_W),
        .INIT ({2'b01, {(SYNC_W - 2){1'b0}}})
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_async   ({i_hard_reset_in, i_select_n, i_pump_low,
                     i_pwm_full_y, i_pwm_full_x, i_overcurrent_y,
                     i_overcurrent_x, i_temp_shutdown, i_temp_warn}),
        .o_sync    (sync_out)
    );

    assign {hard_s, sel_s, pump_s, full_y_s, full_x_s,
            ocy_s, ocx_s, shut_s, warn_s} = sync_out;

    msd_spi_link u_link (
        .i_spi_clk    (i_spi_clk),
        .i_rst        (i_rst),
        .i_select_n   (i_select_n),
        .i_serial_in  (i_serial_in),
        .o_serial_out (o_serial_out),
        .o_serial_oe  (o_serial_oe),
        .i_rd_bytes   (image),
        .o_pkt_bits   (pkt_bits),
        .o_pkt_write  (pkt_write),
        .o_pkt_addr   (pkt_addr),
        .o_pkt_data   (pkt_data),
        .o_read_mask  (read_mask)
    );

    // Register image; static while select is low, so the link reads it
    always_comb
    begin
        sr0                 = STATUS_ZERO;
        sr1                 = STATUS_ZERO;
        sr2                 = STATUS_ZERO;
        sr0[SR0_WARN]       = s_reg.warn;
        sr0[SR0_PUMP]       = s_reg.pump;
        sr0[SR0_OPEN_X]     = s_reg.open_x;
        sr0[SR0_OPEN_Y]     = s_reg.open_y;
        sr1[SR1_OC_LSB +: OC_W] = s_reg.oc_x;
        sr2[SR2_OC_LSB +: OC_W] = s_reg.oc_y;
        sr2[SR2_SHUTDOWN]   = s_reg.shutdown;
        image               = {REG_COUNT{UNMAPPED_VAL}};
        image[ADDR_CR0[IDX_W-1:0]] = s_reg.cr0;                    // RULE_17
        image[ADDR_CR1[IDX_W-1:0]] = s_reg.cr1;
        image[ADDR_CR2[IDX_W-1:0]] = s_reg.cr2;
        image[ADDR_SR0[IDX_W-1:0]] = msd_with_parity(sr0);         // RULE_17
        image[ADDR_SR1[IDX_W-1:0]] = msd_with_parity(sr1);
        image[ADDR_SR2[IDX_W-1:0]] = msd_with_parity(sr2);
        image[ADDR_SR3[IDX_W-1:0]] = msd_with_parity(STATUS_ZERO);
    end

    // Packet record is frozen once select is high, so taking it here is safe
    assign commit   = sel_s && !s_reg.sel_d;
    assign wr_ok    = commit && pkt_bits == PKT_BITS && pkt_write;  // RULE_23
    assign rd_sr0   = commit && read_mask[ADDR_SR0[IDX_W-1:0]];     // RULE_19
    assign rd_sr1   = commit && read_mask[ADDR_SR1[IDX_W-1:0]];
    assign rd_sr2   = commit && read_mask[ADDR_SR2[IDX_W-1:0]];
    assign any_flag = s_reg.warn || s_reg.shutdown || (|s_reg.oc_x) ||
                      (|s_reg.oc_y) || s_reg.open_x || s_reg.open_y ||
                      s_reg.pump;

    always_comb
    begin
        s_next       = s_reg;
        s_next.sel_d = sel_s;
        s_next.cnt_x = open_step(full_x_s, s_reg.drv_x, s_reg.cnt_x); // RULE_06
        s_next.cnt_y = open_step(full_y_s, s_reg.drv_y, s_reg.cnt_y);
        // Set beats a clear in the same cycle
        if (sel_s)
        begin
            s_next.warn     = warn_s || (s_reg.warn && !rd_sr0);   // RULE_01
            s_next.shutdown = shut_s ||
                              (s_reg.shutdown && !(rd_sr2 && !warn_s)); // RULE_03
            s_next.oc_x     = (ocx_s & {OC_W{s_reg.drv_x}}) |
                              (s_reg.oc_x & {OC_W{!rd_sr1}});      // RULE_04
            s_next.oc_y     = (ocy_s & {OC_W{s_reg.drv_y}}) |
                              (s_reg.oc_y & {OC_W{!rd_sr2}});      // RULE_05
            s_next.open_x   = (s_reg.cnt_x == LIMIT) ||
                              (s_reg.open_x && !rd_sr0);           // RULE_06
            s_next.open_y   = (s_reg.cnt_y == LIMIT) ||
                              (s_reg.open_y && !rd_sr0);
            s_next.pump     = pump_s || (s_reg.pump && !rd_sr0);   // RULE_07
            s_next.err_n    = !any_flag;                           // RULE_08
        end
        if (wr_ok)
        begin
            unique case (pkt_addr)
                ADDR_CR0: s_next.cr0 = pkt_data;                   // RULE_21
                ADDR_CR1: s_next.cr1 = pkt_data;
                ADDR_CR2: s_next.cr2 = pkt_data;
                default:  s_next.cr0 = s_reg.cr0;                  // RULE_24
            endcase
        end
        // Shutdown or any over-current flag takes both bridges off; an open-coil flag takes off only its own bridge
        s_next.drv_x = s_reg.cr2[CR2_MOTOR_EN] && !s_reg.cr2[CR2_SLEEP] &&
                       !s_reg.shutdown && !(|s_reg.oc_x) &&
                       !(|s_reg.oc_y) && !s_reg.open_x;            // RULE_02
        s_next.drv_y = s_reg.cr2[CR2_MOTOR_EN] && !s_reg.cr2[CR2_SLEEP] &&
                       !s_reg.shutdown && !(|s_reg.oc_x) &&
                       !(|s_reg.oc_y) && !s_reg.open_y;            // RULE_10
        s_next.pump_run = !s_reg.cr2[CR2_SLEEP];                   // RULE_10
        // Clocks stay up in sleep only while a frame is in progress
        s_next.osc_run  = !s_reg.cr2[CR2_SLEEP] || !sel_s;         // RULE_10
        if (hard_s)
            s_next = CORE_RST;                                     // RULE_09
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            s_reg <= CORE_RST;
        else
            s_reg <= s_next;
    end

    assign o_error_out_n = s_reg.err_n;
    assign o_drive_en_x  = s_reg.drv_x;
    assign o_drive_en_y  = s_reg.drv_y;
    assign o_pump_run    = s_reg.pump_run;
    assign o_osc_run     = s_reg.osc_run;
    assign o_ctrl0       = s_reg.cr0;
    assign o_ctrl1       = s_reg.cr1;
    assign o_ctrl2       = s_reg.cr2;

    a_warn_sets : assert property ( // RULE_01
        @(posedge i_ref_clk) disable iff (i_rst)
        (sel_s && warn_s && !hard_s) |=> s_reg.warn)
        else $error("warning flag not set");

    a_shutdown_off : assert property ( // RULE_02
        @(posedge i_ref_clk) disable iff (i_rst)
        s_reg.shutdown |=> !o_drive_en_x && !o_drive_en_y)
        else $error("drivers on during thermal shutdown");

    a_shutdown_clr : assert property ( // RULE_03
        @(posedge i_ref_clk) disable iff (i_rst || hard_s)
        $fell(s_reg.shutdown) |-> $past(rd_sr2) && !$past(warn_s))
        else $error("shutdown flag cleared without read while cool");

    a_oc_latched : assert property ( // RULE_05
        @(posedge i_ref_clk) disable iff (i_rst || hard_s)
        ((|s_reg.oc_x) && !rd_sr1) |=> (|s_reg.oc_x) ##1 !o_drive_en_x)
        else $error("over-current flag lost without read");

    a_open_coil : assert property ( // RULE_06
        @(posedge i_ref_clk) disable iff (i_rst || hard_s)
        (sel_s && s_reg.cnt_x == LIMIT) |=> s_reg.open_x ##1 !o_drive_en_x)
        else $error("open coil not flagged at limit");

    a_pump_hold : assert property ( // RULE_07
        @(posedge i_ref_clk) disable iff (i_rst || hard_s)
        (sel_s && pump_s) |=> s_reg.pump)
        else $error("pump failure flag not held");

    a_error_out : assert property ( // RULE_08
        @(posedge i_ref_clk) disable iff (i_rst || hard_s)
        (sel_s && any_flag) |=> !o_error_out_n)
        else $error("error output not asserted");

    a_error_frozen : assert property ( // RULE_19
        @(posedge i_ref_clk) disable iff (i_rst || hard_s)
        !sel_s |=> $stable(o_error_out_n) && $stable(s_reg.warn))
        else $error("status moved while selected");

    a_write_commit : assert property ( // RULE_21
        @(posedge i_ref_clk) disable iff (i_rst || hard_s)
        (wr_ok && pkt_addr == ADDR_CR2) |=> o_ctrl2 == $past(pkt_data))
        else $error("write not committed on select rise");

    a_bad_write : assert property ( // RULE_23
        @(posedge i_ref_clk) disable iff (i_rst || hard_s)
        !wr_ok |=> $stable(o_ctrl0) && $stable(o_ctrl1) && $stable(o_ctrl2))
        else $error("control changed without a valid write");

    a_sleep_hiz : assert property ( // RULE_10
        @(posedge i_ref_clk) disable iff (i_rst || hard_s)
        s_reg.cr2[CR2_SLEEP] |=> !o_drive_en_x && !o_drive_en_y && !o_pump_run)
        else $error("drivers active in sleep");

    a_hard_reset : assert property ( // RULE_09
        @(posedge i_ref_clk) disable iff (i_rst)
        hard_s |=> o_ctrl2 == CTRL_RESET ##1 o_pump_run)
        else $error("hard reset did not clear registers");

endmodule : msd_top

// [msd_top_tb.sv]
// Purpose: Self-checking bench for the SPI diagnostics block
// Assumes: Short open-coil limit, master model on the link
// Notes:   Control expectations come from a local register model
module msd_top_tb
    import msd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int   LIM = 20;
    logic            clk, rst, sck, sel_n, sdi, sdo, oe, err_n, dex, dey;
    logic            pump, osc, warn, shut, pfx, pfy, plow, hrst;
    logic [OC_W-1:0] ocx, ocy;
    logic [7:0]      c0, c1, c2, d;
    logic [16:0]     rx;
    logic [7:0]      ctrl_m [1:3];
    int              n_fail, check_count, cycles, seed, k;

    msd_top #(.OPEN_LIMIT(LIM)) i_msd_top (.i_ref_clk(clk), .i_rst(rst),
        .i_spi_clk(sck), .i_select_n(sel_n), .i_serial_in(sdi),
        .o_serial_out(sdo), .o_serial_oe(oe), .i_temp_warn(warn),
        .i_temp_shutdown(shut), .i_overcurrent_x(ocx),
        .i_overcurrent_y(ocy), .i_pwm_full_x(pfx), .i_pwm_full_y(pfy),
        .i_pump_low(plow), .i_hard_reset_in(hrst), .o_error_out_n(err_n),
        .o_drive_en_x(dex), .o_drive_en_y(dey), .o_pump_run(pump),
        .o_osc_run(osc), .o_ctrl0(c0), .o_ctrl1(c1), .o_ctrl2(c2));
    msd_spi_host i_msd_spi_host (.o_spi_clk(sck), .o_select_n(sel_n),
        .o_serial_in(sdi), .i_serial_out(sdo), .i_serial_oe(oe));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] v, input int n);
        i_msd_spi_host.xfer({CMD_WRITE, 2'b00, a, v, 1'b0} >> (17 - n), n, rx);
        cyc(6);
    endtask : wr
    task automatic rd(input logic [4:0] a);
        i_msd_spi_host.xfer({1'b0, CMD_READ, 2'b00, a, 8'h00}, 16, rx);
        if (a >= ADDR_SR0 && (^rx[7:0]))
        begin
            cyc(6);
            i_msd_spi_host.xfer({1'b0, CMD_READ, 2'b00, a, 8'h00}, 16, rx);
        end
        d = rx[7:0];
        cyc(6);
    endtask : rd
    task automatic finish_test();
        $display("TB: %0d checks, %0d failures", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            n_fail++;
            finish_test();
        end
    end

    initial
    begin
        seed = 16405;
        {warn, shut, pfx, pfy, hrst, ocx, ocy} = '0;
        {rst, plow} = 2'b11;
        ctrl_m = '{8'h00, 8'h00, 8'h00};
        cyc(12);
        chk({c0, c1, c2, err_n}, 1);
        rst <= 1'b0;
        cyc(8);
        chk(err_n, 0);
        rd(ADDR_SR0);
        chk(d, 8'ha0);
        plow <= 1'b0;
        rd(ADDR_SR0);
        warn <= 1'b1;
        cyc(8);
        chk({err_n, oe}, 0);
        rd(ADDR_SR0);
        chk(d, 8'hc0);
        warn <= 1'b0;
        rd(ADDR_SR0);
        rd(ADDR_SR0);
        chk({d, err_n}, 1);
        k = $random(seed);
        ctrl_m[1] = k[7:0];
        wr(ADDR_CR0, ctrl_m[1], 16);
        wr(ADDR_CR1, 8'h5a, 17);
        wr(ADDR_CR1, 8'h5a, 15);
        wr(ADDR_SR0, 8'h7f, 16);
        chk({c0, c1, c2}, {ctrl_m[1], ctrl_m[2], ctrl_m[3]});
        rd(ADDR_CR0);
        chk(d, ctrl_m[1]);
        rd(ADDR_SR0);
        chk(d, 0);
        ctrl_m[3] = 8'h80;
        wr(ADDR_CR2, ctrl_m[3], 16);
        chk({dex, dey}, 2'b11);
        k = {$random(seed)} % OC_W;
        ocx[k] <= 1'b1;
        cyc(8);
        ocx <= '0;
        cyc(8);
        chk({dex, dey, err_n}, 0);
        rd(ADDR_SR1);
        chk(d, 8'h80 | (8'h01 << (3 + k)));
        chk({dex, dey}, 2'b11);
        pfx <= 1'b1;
        cyc(LIM + 10);
        pfx <= 1'b0;
        chk({dex, dey}, 2'b01);
        rd(ADDR_SR0);
        chk(d, 8'h88);
        shut <= 1'b1;
        warn <= 1'b1;
        cyc(8);
        chk({dex, dey, err_n}, 0);
        shut <= 1'b0;
        rd(ADDR_SR2);
        chk(d, 8'h84);
        rd(ADDR_SR2);
        chk(d, 8'h84);
        warn <= 1'b0;
        rd(ADDR_SR2);
        rd(ADDR_SR2);
        chk(d, 0);
        // No step inputs are driven while asleep
        ctrl_m[3] = 8'hc0;
        wr(ADDR_CR2, ctrl_m[3], 16);
        chk(rx[7:0], 8'h80);
        chk({dex, dey, pump, osc}, 0);
        rd(ADDR_CR2);
        chk(d, ctrl_m[3]);
        hrst <= 1'b1;
        cyc(8);
        chk({c0, c1, c2, pump}, 1);
        hrst <= 1'b0;
        finish_test();
    end
endmodule : msd_top_tb
